// *** hdl/cledp_consts.svh ***
// constants for the charger led indicator pwm block
`ifndef CLEDP_CONSTS_SVH
`define CLEDP_CONSTS_SVH
`define CLEDP_ADDR_CONTROL 4'h0
`define CLEDP_ADDR_DUTY 4'h1
`define CLEDP_ADDR_STATUS 4'h2
`define CLEDP_CTRL_EN_BIT 0
`define CLEDP_CTRL_CUR_LSB 1
`define CLEDP_CTRL_CUR_MSB 3
`define CLEDP_CTRL_RESET 8'h00
`define CLEDP_DUTY_RESET 8'h00
`define CLEDP_HW_CURRENT 3'h1
`define CLEDP_FULL_DUTY 8'hFF
`define CLEDP_PWM_STEPS 256
`endif

// *** hdl/cledp_pkg.sv ***
// types for the charger led indicator pwm block
package cledp_pkg;
  typedef enum logic [0:0] {CLEDP_HW = 1'b0, CLEDP_SW = 1'b1} cledp_mode_e;
  typedef struct packed {
    cledp_mode_e mode;
    logic [7:0] control;
    logic [7:0] duty;
    logic [7:0] pwm_cnt;
    logic [7:0] rdata;
    logic [1:0] tick_sync;
    logic tick_prev;
    logic [1:0] main_sync;
    logic [1:0] usb_sync;
    logic [1:0] valid_sync;
    logic [1:0] batt_sync;
    logic led_on;
    logic [2:0] led_current;
    logic charge_en;
  } cledp_state_s;
endpackage : cledp_pkg

// *** hdl/cledp_top.sv ***
// charger led indicator: hardware charging mode and software pwm mode
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "cledp_consts.svh"
module cledp_top
  import cledp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk32k_tick,
  input wire logic main_charger_present,
  input wire logic usb_charger_present,
  input wire logic charger_valid,
  input wire logic battery_ok_level,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  output logic led_on,
  output logic [2:0] led_current,
  output logic charge_en,
  output logic sw_mode
);

  cledp_state_s st;
  cledp_state_s next_st;
  logic tick_rise;
  logic pwm_active;
  logic charger_att;
  logic charger_good;
  logic battery_reached;
  logic sw_enable;
  logic [2:0] sw_current;
  logic status_mode;

  // two-stage synchroniser shift: the new pin value enters stage 0
  function automatic logic [1:0] sync_shift(input logic [1:0] stage, input logic pin);
    sync_shift = {stage[0], pin};
  endfunction : sync_shift

  // compare used for the pwm phase; 8-bit count against 8-bit duty
  function automatic logic pwm_below(input logic [7:0] cnt, input logic [7:0] duty);
    pwm_below = (cnt < duty);
  endfunction : pwm_below

  // current code field of the control register
  function automatic logic [2:0] current_field(input logic [7:0] ctrl);
    current_field = ctrl[`CLEDP_CTRL_CUR_MSB:`CLEDP_CTRL_CUR_LSB];
  endfunction : current_field

  // status word layout of the read path
  function automatic logic [7:0] status_word(
    input logic valid,
    input logic att,
    input logic chg,
    input logic led,
    input logic swm
  );
    status_word = {3'h0, valid, att, chg, led, swm};
  endfunction : status_word

  // derived terms, read only from the second synchroniser stage
  always_comb
  begin
    tick_rise = st.tick_sync[1] & ~st.tick_prev;
    charger_att = st.main_sync[1] | st.usb_sync[1];
    charger_good = charger_att & st.valid_sync[1];
    battery_reached = st.batt_sync[1];
    sw_enable = st.control[`CLEDP_CTRL_EN_BIT];
    sw_current = current_field(st.control);
    status_mode = (st.mode == CLEDP_SW);
    pwm_active = pwm_below(st.pwm_cnt, st.duty);
  end

  // next state
  always_comb
  begin
    next_st = st;
    // synchronisers; the first stage is never read by logic
    next_st.tick_sync = sync_shift(st.tick_sync, clk32k_tick);
    next_st.main_sync = sync_shift(st.main_sync, main_charger_present);
    next_st.usb_sync = sync_shift(st.usb_sync, usb_charger_present);
    next_st.valid_sync = sync_shift(st.valid_sync, charger_valid);
    next_st.batt_sync = sync_shift(st.batt_sync, battery_ok_level);
    next_st.tick_prev = st.tick_sync[1];

    // counter wraps every 256 ticks, giving 32.768 kHz / 256
    if (tick_rise)
    begin
      if (st.pwm_cnt == 8'hFF)
      begin
        next_st.pwm_cnt = 8'h00;
      end
      else
      begin
        next_st.pwm_cnt = st.pwm_cnt + 8'h01;
      end
    end

    // one-way handover: only a reset brings hardware mode back
    case (st.mode)
      CLEDP_HW:
      begin
        if (battery_reached)
        begin
          next_st.mode = CLEDP_SW;
        end
      end
      CLEDP_SW:
      begin
        next_st.mode = CLEDP_SW;
      end
      default:
      begin
        next_st.mode = CLEDP_HW;
      end
    endcase

    // register writes; accepted in either mode, applied only in software mode
    if (wr_en)
    begin
      case (addr)
        `CLEDP_ADDR_CONTROL:
        begin
          next_st.control = wdata;
        end
        `CLEDP_ADDR_DUTY:
        begin
          next_st.duty = wdata;
        end
        default:
        begin
          next_st.control = st.control; // unmapped writes dropped
        end
      endcase
    end

    // read data stands only in the cycle after the strobe, zero otherwise
    next_st.rdata = 8'h00;
    if (rd_en)
    begin
      case (addr)
        `CLEDP_ADDR_CONTROL:
        begin
          next_st.rdata = st.control;
        end
        `CLEDP_ADDR_DUTY:
        begin
          next_st.rdata = st.duty;
        end
        `CLEDP_ADDR_STATUS:
        begin
          next_st.rdata = status_word(st.valid_sync[1], charger_att, st.charge_en,
                                      st.led_on, status_mode);
        end
        default:
        begin
          next_st.rdata = 8'h00;
        end
      endcase
    end

    // led outputs
    case (st.mode)
      CLEDP_HW:
      begin
        next_st.charge_en = charger_att;
        next_st.led_on = charger_good;
        next_st.led_current = `CLEDP_HW_CURRENT;
      end
      CLEDP_SW:
      begin
        next_st.charge_en = 1'b0;
        next_st.led_on = sw_enable & pwm_active;
        next_st.led_current = sw_current;
      end
      default:
      begin
        next_st.charge_en = 1'b0;
        next_st.led_on = 1'b0;
        next_st.led_current = 3'h0;
      end
    endcase
  end

  // state register; constants only under reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.mode <= CLEDP_HW;
      st.control <= `CLEDP_CTRL_RESET;
      st.duty <= `CLEDP_DUTY_RESET;
      st.pwm_cnt <= 8'h00;
      st.rdata <= 8'h00;
      st.tick_sync <= 2'h0;
      st.tick_prev <= 1'b0; // matches idle tick level, no false edge
      st.main_sync <= 2'h0;
      st.usb_sync <= 2'h0;
      st.valid_sync <= 2'h0;
      st.batt_sync <= 2'h0;
      st.led_on <= 1'b0;
      st.led_current <= 3'h0;
      st.charge_en <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign rdata = st.rdata;
  assign led_on = st.led_on;
  assign led_current = st.led_current;
  assign charge_en = st.charge_en;
  assign sw_mode = (st.mode == CLEDP_SW);

endmodule : cledp_top

// *** tb/cledp_properties.sv ***
// port checker for the led indicator
`timescale 1ns/1ps
`include "cledp_consts.svh"
module cledp_properties (
  input wire logic clk, rst_n, main_charger_present, usb_charger_present, charger_valid,
  input wire logic battery_ok_level, rd_en, led_on, charge_en, sw_mode,
  input wire logic [3:0] addr,
  input wire logic [2:0] led_current,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // pins pass two sync flops, so look back 3 and 4 edges
  wire g = (main_charger_present || usb_charger_present) && charger_valid;
  wire s = sw_mode;
  a_hw_on: assert property (!s && $past(g, 3) && $past(g, 4) |-> led_on && charge_en) else $error("on");
  a_hw_off: assert property (!s && !$past(g, 3) && !$past(g, 4) |-> !led_on) else $error("off");
  a_hw_cur: assert property (!s && $past(rst_n) |-> led_current == `CLEDP_HW_CURRENT) else $error("cur");
  a_mode_hold: assert property (s |=> s) else $error("hold");
  a_sw_entry: assert property ($past(battery_ok_level, 3) && $past(battery_ok_level, 4) |-> s) else $error("entry");
  a_sw_nocharge: assert property (s && $past(s) |-> !charge_en) else $error("chg");
  a_rd_idle: assert property (!$past(rd_en) |-> rdata == 8'h00) else $error("idle");
  a_rd_status: assert property ($past(rd_en) && $past(addr) == `CLEDP_ADDR_STATUS
    |-> rdata[2:0] == {$past(charge_en), $past(led_on), $past(s)}) else $error("stat");
  cover property (!s && led_on);
  cover property (s && led_on);
  cover property ($past(rd_en) && s);
endmodule : cledp_properties

// *** tb/cledp_led_model.sv ***
// indicator led model: counts lit clock cycles
`timescale 1ns/1ps
module cledp_led_model (
  input wire logic clk, clr, led_on,
  output logic [15:0] on_cnt
);
  // the led has no memory: lit exactly while driven
  always_ff @(posedge clk)
    on_cnt <= clr ? 16'h0000 : on_cnt + {15'h0000, led_on};
endmodule : cledp_led_model

// *** tb/test_charger_led_indicator_pwm.sv ***
// bench for the led indicator top
`timescale 1ns/1ps
`include "cledp_consts.svh"
module test_charger_led_indicator_pwm;
  logic clk = 1'b0, rst_n = 1'b0, main_charger_present = 1'b0, usb_charger_present = 1'b0, charger_valid = 1'b0;
  logic battery_ok_level = 1'b0, wr_en = 1'b0, rd_en = 1'b0, clr = 1'b0, led_on, charge_en, sw_mode;
  logic [1:0] tc = 2'h0;
  logic [2:0] led_current;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [15:0] on_cnt;
  logic [31:0] r = 32'h98E0;
  int fails = 0, check_count = 0, cyc = 0;
  cledp_top dut (
    .clk(clk),
    .rst_n(rst_n),
    .clk32k_tick(tc[1]),
    .main_charger_present(main_charger_present),
    .usb_charger_present(usb_charger_present),
    .charger_valid(charger_valid),
    .battery_ok_level(battery_ok_level),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .led_on(led_on),
    .led_current(led_current),
    .charge_en(charge_en),
    .sw_mode(sw_mode)
  );
  cledp_led_model led (.clk(clk), .clr(clr), .led_on(led_on), .on_cnt(on_cnt));
  initial forever #10 clk = ~clk;
  // 4-clock tick keeps a pwm period at 1024 clocks
  always @(posedge clk)
  begin
    tc <= tc + 2'h1;
    cyc <= cyc + 1;
    if (cyc > 15000)
      test_done(1);
  end
  task automatic test_done(input int h);
    if (fails + h == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] a, e);
    check_count++;
    if (a !== e)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, a, e);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  // one strobe cycle; a read is checked in the following cycle only
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] v);
    w(1);
    {wr_en, rd_en, addr, wdata} <= {wr, !wr, a, v};
    w(1);
    {wr_en, rd_en} <= 2'h0;
    #1 if (!wr) chk({8'h00, rdata}, {8'h00, v});
  endtask : bus
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  initial
  begin
    w(16);
    rst_n <= 1'b1;
    main_charger_present <= 1'b1;
    w(8);
    charger_valid <= 1'b1;
    #1 chk(led_on, 1'b0);
    bus(1'b1, `CLEDP_ADDR_CONTROL, 8'h0B);
    w(8);
    battery_ok_level <= 1'b1;
    #1 chk({led_on, charge_en, led_current}, 5'h19);
    w(8);
    #1 chk({sw_mode, charge_en, led_current}, 5'h15);
    // zero, full and two random duties; lit clocks = duty * 4
    for (int i = 0; i < 4; i++)
    begin
      r = xs(r);
      if (i < 2)
        r[7:0] = i ? 8'hFF : 8'h00;
      bus(1'b1, `CLEDP_ADDR_DUTY, r[7:0]);
      bus(1'b0, `CLEDP_ADDR_DUTY, r[7:0]);
      w(1100);
      clr <= 1'b1;
      w(1);
      clr <= 1'b0;
      w(1024);
      #1 chk(on_cnt, {6'h00, r[7:0], 2'h0});
    end
    bus(1'b1, `CLEDP_ADDR_CONTROL, 8'h0A);
    bus(1'b0, 4'hF, 8'h00);
    w(1100);
    bus(1'b0, `CLEDP_ADDR_STATUS, 8'h19);
    test_done(0);
  end
endmodule : test_charger_led_indicator_pwm
bind cledp_top cledp_properties prop (.*);
